// ### verilog/gps_pin_select.sv
/*
 * Four general-pin function selects, password/settings report bytes and the
 * chip-reset command check, reached over a Wishbone classic slave.
 * Assumes all inputs synchronous to clk; pad drivers sit outside and take out/oe.
 */
// Local design decisions: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - pin 0 codes: 0 gpio, 1 suspend indicator, 2 receive LED, others no effect.
// - pin 1 codes: 0 gpio, 1 clock ref, 2 analog in 1, 3 transmit LED, 4 interrupt.
// - pin 2 codes: 0 gpio, 1 enumeration done, 2 analog in 2, 3 analog out 1.
// - pin 3 codes: 0 gpio, 1 i2c LED, 2 analog in 3, 3 analog out 2.
// - gpio output pins drive settings bit 4.
// - bit 3 sets direction (1 in, 0 out) only in gpio mode; bits 7..5 ignored.
// - pin settings bytes sit at report indices 22..25; 26..63 carry nothing.
// - password bytes 4..8 sit at report indices 17..21 ascending.
// - reset command gets no response report; host must not wait.
// - valid reset command triggers full reset and re-enumeration.
module gps_pin_select
    import gps_pkg::*;
#(
    parameter int PINS = 4
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    input  wire gps_src_t    alt_src,
    input  wire logic [3:0]  pin_in,
    output logic      [3:0]  pin_out,
    output logic      [3:0]  pin_oe,
    output gps_alt_t         alt_en,
    output logic             chip_reset_req,
    output logic             reenumerate_req
);
    if (PINS != 4) begin : g_bad_pins
        $error("gps_pin_select: only four pins are served");
    end

    function automatic logic [7:0] lane(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel, input int b);
        return sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
    endfunction

    // register state
    logic [7:0]  pin_cfg_r [4];
    logic [7:0]  pin_cfg_nxt [4];
    logic [31:0] pwd_lo_r, pwd_lo_nxt;
    logic [7:0]  pwd_hi_r, pwd_hi_nxt;
    logic        ack_r, ack_nxt;
    logic        err_r, err_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic [5:0]  rep_idx_r, rep_idx_nxt;
    logic [7:0]  ign_cnt_r, ign_cnt_nxt;
    logic [7:0]  rst_cnt_r, rst_cnt_nxt;

    // command checker
    typedef enum logic [1:0] {
        GPS_S_IDLE  = 2'b00,
        GPS_S_SCAN  = 2'b01,
        GPS_S_PULSE = 2'b10
    } gps_state_t;
    gps_state_t  state_r, state_nxt;
    logic [6:0]  scan_r, scan_nxt;
    logic        ok_r, ok_nxt;
    logic [7:0]  pulse_r, pulse_nxt;

    logic       req;
    logic       mem_we;
    logic [5:0] mem_raddr;
    logic [7:0] mem_rdata;

    assign req       = wb_cyc_i & wb_stb_i & ~ack_r & ~err_r;
    assign mem_we    = req & wb_we_i & (wb_adr_i == GPS_OFS_CMD_DATA) & wb_sel_i[0] & (state_r == GPS_S_IDLE);
    assign mem_raddr = scan_r[5:0];

    gps_cmd_mem #(
        .DEPTH (GPS_REPORT_BYTES),
        .AW    (6)
    ) u_mem (
        .clk   (clk),
        .we    (mem_we),
        .waddr (wb_dat_i[13:8]),
        .wdata (wb_dat_i[7:0]),
        .raddr (mem_raddr),
        .rdata (mem_rdata)
    );

    // one byte of the settings report at index idx
    function automatic logic [7:0] report_byte(input logic [5:0] idx);
        logic [7:0] r;
        r = 8'h00;
        if (idx >= GPS_IDX_PWD_FIRST && idx <= GPS_IDX_PWD_LAST) begin
            unique case (6'(idx - GPS_IDX_PWD_FIRST))
                6'h00:   r = pwd_lo_r[7:0];
                6'h01:   r = pwd_lo_r[15:8];
                6'h02:   r = pwd_lo_r[23:16];
                6'h03:   r = pwd_lo_r[31:24];
                default: r = pwd_hi_r;
            endcase
        end else if (idx >= GPS_IDX_PIN_FIRST && idx < 6'(GPS_IDX_PIN_FIRST + 6'h04)) begin
            r = pin_cfg_r[2'(idx - GPS_IDX_PIN_FIRST)];
        end
        return r;
    endfunction

    // pin function decode
    function automatic gps_fn_t pin_fn(input logic [7:0] cfg, input logic [2:0] last_code);
        logic [2:0] d;
        d = cfg[GPS_DESIG_LSB +: GPS_DESIG_W];
        if (d == GPS_D_GPIO) begin
            return cfg[GPS_DIR_BIT] ? GPS_FN_GPIO_IN : GPS_FN_GPIO_OUT;
        end
        return (d <= last_code) ? GPS_FN_ALT : GPS_FN_NONE;
    endfunction

    gps_fn_t    fn [4];
    logic [2:0] code [4];
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            code[i] = pin_cfg_r[i][GPS_DESIG_LSB +: GPS_DESIG_W];
        end
        fn[0] = pin_fn(pin_cfg_r[0], GPS_D_ALT2);
        fn[1] = pin_fn(pin_cfg_r[1], GPS_D_ALT4);
        fn[2] = pin_fn(pin_cfg_r[2], GPS_D_ALT3);
        fn[3] = pin_fn(pin_cfg_r[3], GPS_D_ALT3);
    end

    // alternate enables and pad drive
    always_comb begin
        alt_en = '0;
        alt_en.suspend_indicator       = code[0] == GPS_D_ALT1;
        alt_en.receive_activity_led    = code[0] == GPS_D_ALT2;
        alt_en.clock_ref_out           = code[1] == GPS_D_ALT1;
        alt_en.analog_input_1          = code[1] == GPS_D_ALT2;
        alt_en.transmit_activity_led   = code[1] == GPS_D_ALT3;
        alt_en.interrupt_detect        = code[1] == GPS_D_ALT4;
        alt_en.enumeration_done_output = code[2] == GPS_D_ALT1;
        alt_en.analog_input_2          = code[2] == GPS_D_ALT2;
        alt_en.analog_output_1         = code[2] == GPS_D_ALT3;
        alt_en.i2c_activity_led        = code[3] == GPS_D_ALT1;
        alt_en.analog_input_3          = code[3] == GPS_D_ALT2;
        alt_en.analog_output_2         = code[3] == GPS_D_ALT3;

        for (int i = 0; i < 4; i++) begin
            pin_out[i] = pin_cfg_r[i][GPS_OUT_BIT];
            pin_oe[i]  = fn[i] == GPS_FN_GPIO_OUT;
        end
        // digital alternate outputs drive their pad; analog ones leave it undriven
        if (alt_en.suspend_indicator) begin
            pin_out[0] = alt_src.suspend_indicator;
            pin_oe[0]  = 1'b1;
        end
        if (alt_en.receive_activity_led) begin
            pin_out[0] = alt_src.receive_activity_led;
            pin_oe[0]  = 1'b1;
        end
        if (alt_en.clock_ref_out) begin
            pin_out[1] = alt_src.clock_ref_out;
            pin_oe[1]  = 1'b1;
        end
        if (alt_en.transmit_activity_led) begin
            pin_out[1] = alt_src.transmit_activity_led;
            pin_oe[1]  = 1'b1;
        end
        if (alt_en.enumeration_done_output) begin
            pin_out[2] = alt_src.enumeration_done_output;
            pin_oe[2]  = 1'b1;
        end
        if (alt_en.i2c_activity_led) begin
            pin_out[3] = alt_src.i2c_activity_led;
            pin_oe[3]  = 1'b1;
        end
    end

    // bus slave
    logic submit;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_cfg_nxt[i] = pin_cfg_r[i];
        end
        pwd_lo_nxt  = pwd_lo_r;
        pwd_hi_nxt  = pwd_hi_r;
        rep_idx_nxt = rep_idx_r;
        dat_nxt     = dat_r;
        ack_nxt     = 1'b0;
        err_nxt     = 1'b0;
        submit      = 1'b0;
        if (req) begin
            ack_nxt = 1'b1;
            if (wb_we_i) begin
                unique case (wb_adr_i)
                    GPS_OFS_PIN_CFG: begin
                        for (int i = 0; i < 4; i++) begin
                            if (wb_sel_i[i]) pin_cfg_nxt[i] = wb_dat_i[8*i +: 8];
                        end
                    end
                    GPS_OFS_PWD_LO: begin
                        for (int i = 0; i < 4; i++) begin
                            pwd_lo_nxt[8*i +: 8] = lane(pwd_lo_r, wb_dat_i, wb_sel_i, i);
                        end
                    end
                    GPS_OFS_PWD_HI:   pwd_hi_nxt = wb_sel_i[0] ? wb_dat_i[7:0] : pwd_hi_r;
                    GPS_OFS_REPORT:   rep_idx_nxt = wb_sel_i[0] ? wb_dat_i[5:0] : rep_idx_r;
                    GPS_OFS_CMD_DATA: ;
                    GPS_OFS_CMD_CTRL: submit = wb_sel_i[0] & wb_dat_i[0];
                    GPS_OFS_PIN_STATUS, GPS_OFS_CMD_STATUS: ;
                    default: begin
                        ack_nxt = 1'b0;
                        err_nxt = 1'b1;
                    end
                endcase
            end else begin
                unique case (wb_adr_i)
                    GPS_OFS_PIN_CFG:    dat_nxt = {pin_cfg_r[3], pin_cfg_r[2], pin_cfg_r[1], pin_cfg_r[0]};
                    GPS_OFS_PWD_LO:     dat_nxt = pwd_lo_r;
                    GPS_OFS_PWD_HI:     dat_nxt = {24'h000000, pwd_hi_r};
                    GPS_OFS_PIN_STATUS: dat_nxt = {16'h0000, fn[3], fn[2], fn[1], fn[0], pin_oe, pin_in};
                    GPS_OFS_REPORT:     dat_nxt = {18'h00000, rep_idx_r, report_byte(rep_idx_r)};
                    GPS_OFS_CMD_STATUS: dat_nxt = {15'h0000, state_r != GPS_S_IDLE, rst_cnt_r, ign_cnt_r};
                    GPS_OFS_CMD_DATA, GPS_OFS_CMD_CTRL: dat_nxt = 32'h00000000;
                    default: begin
                        ack_nxt = 1'b0;
                        err_nxt = 1'b1;
                    end
                endcase
            end
        end
    end

    // command scan: byte read lags address by one cycle
    always_comb begin
        state_nxt   = state_r;
        scan_nxt    = scan_r;
        ok_nxt      = ok_r;
        pulse_nxt   = pulse_r;
        ign_cnt_nxt = ign_cnt_r;
        rst_cnt_nxt = rst_cnt_r;
        unique case (state_r)
            GPS_S_IDLE: begin
                if (submit) begin
                    state_nxt = GPS_S_SCAN;
                    scan_nxt  = 7'h00;
                    ok_nxt    = 1'b1;
                end
            end
            GPS_S_SCAN: begin
                scan_nxt = 7'(scan_r + 7'h01);
                if (scan_r != 7'h00) begin
                    unique case (6'(scan_r - 7'h01))
                        6'h00:   ok_nxt = ok_r & (mem_rdata == GPS_CMD_RESET);
                        6'h01:   ok_nxt = ok_r & (mem_rdata == GPS_SIG_0);
                        6'h02:   ok_nxt = ok_r & (mem_rdata == GPS_SIG_1);
                        6'h03:   ok_nxt = ok_r & (mem_rdata == GPS_SIG_2);
                        default: ok_nxt = ok_r & (mem_rdata == 8'h00);
                    endcase
                end
                if (scan_r == 7'(GPS_REPORT_BYTES)) begin
                    // no reply is queued either way: nothing answers this command
                    if (ok_nxt) begin
                        state_nxt   = GPS_S_PULSE;
                        pulse_nxt   = 8'(GPS_RESET_PULSE_CYC);
                        rst_cnt_nxt = 8'(rst_cnt_r + 8'h01);
                    end else begin
                        state_nxt   = GPS_S_IDLE;
                        ign_cnt_nxt = 8'(ign_cnt_r + 8'h01);
                    end
                end
            end
            GPS_S_PULSE: begin
                pulse_nxt = 8'(pulse_r - 8'h01);
                if (pulse_r == 8'h01) state_nxt = GPS_S_IDLE;
            end
            default: state_nxt = GPS_S_IDLE;
        endcase
    end

    assign chip_reset_req  = state_r == GPS_S_PULSE;
    assign reenumerate_req = state_r == GPS_S_PULSE;
    assign wb_ack_o        = ack_r;
    assign wb_err_o        = err_r;
    assign wb_dat_o        = dat_r;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < 4; i++) begin
                pin_cfg_r[i] <= GPS_PIN_CFG_RST;
            end
            pwd_lo_r  <= 32'h00000000;
            pwd_hi_r  <= 8'h00;
            rep_idx_r <= 6'h00;
            dat_r     <= 32'h00000000;
            ack_r     <= 1'b0;
            err_r     <= 1'b0;
            state_r   <= GPS_S_IDLE;
            scan_r    <= 7'h00;
            ok_r      <= 1'b0;
            pulse_r   <= 8'h00;
            ign_cnt_r <= 8'h00;
            rst_cnt_r <= 8'h00;
        end else begin
            pin_cfg_r <= pin_cfg_nxt;
            pwd_lo_r  <= pwd_lo_nxt;
            pwd_hi_r  <= pwd_hi_nxt;
            rep_idx_r <= rep_idx_nxt;
            dat_r     <= dat_nxt;
            ack_r     <= ack_nxt;
            err_r     <= err_nxt;
            state_r   <= state_nxt;
            scan_r    <= scan_nxt;
            ok_r      <= ok_nxt;
            pulse_r   <= pulse_nxt;
            ign_cnt_r <= ign_cnt_nxt;
            rst_cnt_r <= rst_cnt_nxt;
        end
    end
endmodule : gps_pin_select
`default_nettype wire

// ### verilog/gps_pkg.sv
/*
 * Package for the general-pin function select and chip-reset block: register map,
 * settings-byte field layout, designation codes, report layout and reset-command bytes.
 * Assumes a Wishbone classic slave with 32-bit data and one clock.
 */
`default_nettype none
package gps_pkg;

    // register byte addresses (word aligned)
    localparam logic [7:0] GPS_OFS_PIN_CFG    = 8'h00;  // four settings bytes, pin n in byte lane n
    localparam logic [7:0] GPS_OFS_PWD_LO     = 8'h04;  // password bytes 4..7
    localparam logic [7:0] GPS_OFS_PWD_HI     = 8'h08;  // password byte 8
    localparam logic [7:0] GPS_OFS_PIN_STATUS = 8'h0C;  // read-only pin levels and functions
    localparam logic [7:0] GPS_OFS_REPORT     = 8'h10;  // report window, byte index in lane
    localparam logic [7:0] GPS_OFS_CMD_DATA   = 8'h14;  // write: one command byte in bits 7:0, index in bits 13:8
    localparam logic [7:0] GPS_OFS_CMD_CTRL   = 8'h18;  // write 1 to bit 0: submit command
    localparam logic [7:0] GPS_OFS_CMD_STATUS = 8'h1C;  // read: ignored count, reset count

    // settings byte fields
    localparam int GPS_DESIG_LSB = 0;
    localparam int GPS_DESIG_W   = 3;
    localparam int GPS_DIR_BIT   = 3;
    localparam int GPS_OUT_BIT   = 4;

    // designation codes
    localparam logic [2:0] GPS_D_GPIO = 3'h0;
    localparam logic [2:0] GPS_D_ALT1 = 3'h1;
    localparam logic [2:0] GPS_D_ALT2 = 3'h2;
    localparam logic [2:0] GPS_D_ALT3 = 3'h3;
    localparam logic [2:0] GPS_D_ALT4 = 3'h4;

    localparam logic [7:0] GPS_PIN_CFG_RST = 8'h08;  // gpio input, safest at power-up

    // report layout
    localparam int GPS_REPORT_BYTES = 64;
    localparam logic [5:0] GPS_IDX_PWD_FIRST = 6'h11;  // 17
    localparam logic [5:0] GPS_IDX_PWD_LAST  = 6'h15;  // 21
    localparam logic [5:0] GPS_IDX_PIN_FIRST = 6'h16;  // 22

    // chip reset command
    localparam logic [7:0] GPS_CMD_RESET = 8'h70;
    localparam logic [7:0] GPS_SIG_0     = 8'hAB;
    localparam logic [7:0] GPS_SIG_1     = 8'hCD;
    localparam logic [7:0] GPS_SIG_2     = 8'hEF;

    // length of the self-reset pulse, in ns, and in cycles at 250 MHz
    localparam int GPS_CLK_PERIOD_NS  = 4;
    localparam int GPS_RESET_PULSE_NS = 64;
    localparam int GPS_RESET_PULSE_CYC = (GPS_RESET_PULSE_NS + GPS_CLK_PERIOD_NS - 1) / GPS_CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        GPS_FN_GPIO_IN  = 2'b00,
        GPS_FN_GPIO_OUT = 2'b01,
        GPS_FN_ALT      = 2'b10,
        GPS_FN_NONE     = 2'b11
    } gps_fn_t;

    // alternate-function enables per pin
    typedef struct packed {
        logic suspend_indicator;
        logic receive_activity_led;
        logic clock_ref_out;
        logic analog_input_1;
        logic transmit_activity_led;
        logic interrupt_detect;
        logic enumeration_done_output;
        logic analog_input_2;
        logic analog_output_1;
        logic i2c_activity_led;
        logic analog_input_3;
        logic analog_output_2;
    } gps_alt_t;

    // alternate-function sources into the mux
    typedef struct packed {
        logic suspend_indicator;
        logic receive_activity_led;
        logic clock_ref_out;
        logic transmit_activity_led;
        logic enumeration_done_output;
        logic i2c_activity_led;
    } gps_src_t;

endpackage : gps_pkg
`default_nettype wire

// ### verilog/gps_cmd_mem.sv
/*
 * Holds one 64-byte command report written byte by byte; registered read port.
 * Assumes the writer and reader share the single system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module gps_cmd_mem #(
    parameter int DEPTH = 64,
    parameter int AW    = 6
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [7:0]    rdata
);
    if (DEPTH != (1 << AW)) begin : g_bad_size
        $error("gps_cmd_mem: DEPTH must equal 2**AW");
    end

    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : gps_cmd_mem
`default_nettype wire

// ### dv/gps_pin_select_chk.sv
/*
 * Bus and pin-mux assertions for gps_pin_select.
 * Assumes it sees only the top ports, all on clk.
 */
`timescale 1ns/1ps
`default_nettype none
module gps_pin_select_chk
    import gps_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire gps_src_t    alt_src,
    input wire logic [3:0]  pin_out,
    input wire logic [3:0]  pin_oe,
    input wire gps_alt_t    alt_en,
    input wire logic        chip_reset_req,
    input wire logic        reenumerate_req
);
    localparam logic [7:0] PULSE = 8'(GPS_RESET_PULSE_CYC);
    logic [7:0] run_r;
    logic [7:0] run_nxt;
    always_comb begin
        run_nxt = chip_reset_req ? run_r + 8'h01 : 8'h00;
    end
    always_ff @(posedge clk) begin
        run_r <= reset_n ? run_nxt : 8'h00;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    sequence s_answer;
        (wb_ack_o || wb_err_o) ##1 (!wb_ack_o && !wb_err_o);
    endsequence
    bus_answer_a: assert property (s_taken |=> s_answer) else $error("bus answer late or long");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    ack_err_excl_a: assert property (!(wb_ack_o && wb_err_o)) else $error("ack and err together");
    pulse_len_a: assert property ($fell(chip_reset_req) |-> run_r == PULSE) else $error("reset pulse length");
    reset_pair_a: assert property (chip_reset_req == reenumerate_req) else $error("reset pair split");
    pin0_alt_a: assert property ($onehot0({alt_en.suspend_indicator, alt_en.receive_activity_led}))
        else $error("pin 0 two functions");
    pin1_alt_a: assert property ($onehot0(alt_en[9:6])) else $error("pin 1 two functions");
    pin2_alt_a: assert property ($onehot0(alt_en[5:3])) else $error("pin 2 two functions");
    pin3_alt_a: assert property ($onehot0(alt_en[2:0])) else $error("pin 3 two functions");
    analog_hiz_a: assert property ((alt_en.analog_input_1 || alt_en.interrupt_detect) |-> !pin_oe[1])
        else $error("pin 1 driven in analog mode");
    suspend_drive_a: assert property (alt_en.suspend_indicator |->
        pin_oe[0] && pin_out[0] == alt_src.suspend_indicator) else $error("suspend not driven");
    i2c_drive_a: assert property (alt_en.i2c_activity_led |->
        pin_oe[3] && pin_out[3] == alt_src.i2c_activity_led) else $error("i2c led not driven");
endmodule : gps_pin_select_chk
bind gps_pin_select gps_pin_select_chk u_chk (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .alt_src(alt_src), .pin_out(pin_out), .pin_oe(pin_oe),
    .alt_en(alt_en), .chip_reset_req(chip_reset_req), .reenumerate_req(reenumerate_req));
`default_nettype wire

// ### dv/gps_host_model.sv
/*
 * Host side: Wishbone classic master that stages 64-byte command reports.
 * Assumes a slave that answers with ack or err; the bench timeout ends hangs.
 */
`timescale 1ns/1ps
`default_nettype none
module gps_host_model
    import gps_pkg::*;
(
    input  wire logic        clk,
    output logic             wb_cyc_o,
    output logic             wb_stb_o,
    output logic             wb_we_o,
    output logic      [7:0]  wb_adr_o,
    output logic      [3:0]  wb_sel_o,
    output logic      [31:0] wb_dat_o,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic        wb_ack_i,
    input  wire logic        wb_err_i
);
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o  = 1'b0;
        wb_adr_o = 8'h00;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge clk);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o  <= w;
        wb_adr_o <= a;
        wb_sel_o <= s;
        wb_dat_o <= d;
        do @(posedge clk); while (wb_ack_i !== 1'b1 && wb_err_i !== 1'b1);
        r = wb_dat_i;
        e = wb_err_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        // released data must not keep looking valid
        wb_dat_o <= ~d;
    endtask : xfer
    task automatic send_cmd(input logic [23:0] sig, input logic [7:0] tail);
        logic [7:0]  b;
        logic [31:0] r;
        logic        e;
        for (int i = 0; i < 64; i++) begin
            b = (i == 0) ? GPS_CMD_RESET : (i < 4) ? sig[8*(3-i) +: 8] : (i == 63) ? tail : 8'h00;
            xfer(1'b1, GPS_OFS_CMD_DATA, 4'hF, {18'h0, i[5:0], b}, r, e);
        end
        // no reply is ever expected, so the host returns right after submitting
        xfer(1'b1, GPS_OFS_CMD_CTRL, 4'hF, 32'h1, r, e);
    endtask : send_cmd
endmodule : gps_host_model
`default_nettype wire

// ### dv/testbench.sv
/*
 * Self-checking bench for gps_pin_select: random pin settings, report window, reset commands.
 * Assumes gps_host_model as bus master and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin n_checks++; if ((a) !== (e)) begin num_errors++; $display("BAD %0t %s", $time, m); end end
module testbench;
    import gps_pkg::*;
    logic        clk, reset_n, cyc, stb, we, ack, err, rst_req, reen;
    logic [7:0]  adr;
    logic [3:0]  sel, pin_in, pin_out, pin_oe, lanes;
    logic [31:0] wdat, rdat, cfg, pwd_lo, pwd_hi, r, rnd;
    logic        e;
    gps_src_t    alt_src;
    gps_alt_t    alt_en;
    logic [19:0] x;
    int          num_errors, n_checks;
    integer      seed;
    gps_host_model host (.clk(clk), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel),
        .wb_dat_o(wdat), .wb_dat_i(rdat), .wb_ack_i(ack), .wb_err_i(err));
    gps_pin_select dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .alt_src(alt_src),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .alt_en(alt_en), .chip_reset_req(rst_req),
        .reenumerate_req(reen));
    function automatic logic [19:0] exp_pins(input logic [31:0] c, input gps_src_t s);
        gps_alt_t   a;
        logic [3:0] o, d;
        a = '0;
        o = '0;
        d = '0;
        for (int p = 0; p < 4; p++) begin
            if (c[8*p +: 3] == GPS_D_GPIO) begin
                d[p] = !c[8*p+3];
                o[p] = c[8*p+4];
            end
            case ({p[1:0], c[8*p +: 3]})
                5'h01: begin a.suspend_indicator = 1'b1; d[0] = 1'b1; o[0] = s.suspend_indicator; end
                5'h02: begin a.receive_activity_led = 1'b1; d[0] = 1'b1; o[0] = s.receive_activity_led; end
                5'h09: begin a.clock_ref_out = 1'b1; d[1] = 1'b1; o[1] = s.clock_ref_out; end
                5'h0A: a.analog_input_1 = 1'b1;
                5'h0B: begin a.transmit_activity_led = 1'b1; d[1] = 1'b1; o[1] = s.transmit_activity_led; end
                5'h0C: a.interrupt_detect = 1'b1;
                5'h11: begin a.enumeration_done_output = 1'b1; d[2] = 1'b1; o[2] = s.enumeration_done_output; end
                5'h12: a.analog_input_2 = 1'b1;
                5'h13: a.analog_output_1 = 1'b1;
                5'h19: begin a.i2c_activity_led = 1'b1; d[3] = 1'b1; o[3] = s.i2c_activity_led; end
                5'h1A: a.analog_input_3 = 1'b1;
                5'h1B: a.analog_output_2 = 1'b1;
                default: ;
            endcase
        end
        return {a, d, o & d};
    endfunction : exp_pins
    function automatic logic [7:0] rep_byte(input int i);
        if (i >= 17 && i <= 20) return pwd_lo[8*(i-17) +: 8];
        if (i == 21) return pwd_hi[7:0];
        if (i >= 22 && i <= 25) return cfg[8*(i-22) +: 8];
        return 8'h00;
    endfunction : rep_byte
    function automatic logic [1:0] exp_fn(input int p);
        if (cfg[8*p +: 3] == GPS_D_GPIO) return {1'b0, !cfg[8*p+3]};
        return (cfg[8*p +: 3] <= ((p == 0) ? 2 : (p == 1) ? 4 : 3)) ? 2'b10 : 2'b11;
    endfunction : exp_fn
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    task automatic cmd_test(input logic [23:0] sig, input logic [7:0] tail, input int len);
        int hi;
        hi = 0;
        host.send_cmd(sig, tail);
        repeat (120) begin
            @(negedge clk);
            if (rst_req !== 1'b0) hi++;
        end
        `CHK(hi, len, "reset pulse length")
        $display("command test done");
    endtask : cmd_test
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
    initial begin
        seed = 32'hb13598b8;
        reset_n = 1'b0;
        alt_src = '0;
        pin_in = 4'h0;
        num_errors = 0;
        n_checks = 0;
        cfg = {4{GPS_PIN_CFG_RST}};
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        host.xfer(1'b0, GPS_OFS_PIN_CFG, 4'hF, 32'h0, r, e);
        `CHK(r, cfg, "settings reset value")
        `CHK(pin_oe, 4'h0, "pins driven after reset")
        // eight passes walk every code on every pin, the rest are random with random lanes
        for (int n = 0; n < 40; n++) begin
            rnd = $random(seed);
            lanes = (n < 8) ? 4'hF : 4'($random(seed));
            if (n < 8) rnd = (rnd & 32'hF8F8F8F8) | {4{5'h00, n[2:0]}};
            host.xfer(1'b1, GPS_OFS_PIN_CFG, lanes, rnd, r, e);
            for (int l = 0; l < 4; l++) if (lanes[l]) cfg[8*l +: 8] = rnd[8*l +: 8];
            @(posedge clk);
            alt_src <= gps_src_t'($random(seed));
            pin_in <= 4'($random(seed));
            @(negedge clk);
            x = exp_pins(cfg, alt_src);
            `CHK(alt_en, x[19:8], "alternate enables")
            `CHK(pin_oe, x[7:4], "pin drive enables")
            `CHK(pin_out & pin_oe, x[3:0], "pin levels")
            host.xfer(1'b0, GPS_OFS_PIN_STATUS, 4'hF, 32'h0, r, e);
            `CHK(r, {16'h0, exp_fn(3), exp_fn(2), exp_fn(1), exp_fn(0), x[7:4], pin_in}, "pin status")
        end
        $display("pin test done");
        pwd_lo = $random(seed);
        pwd_hi = {24'h0, 8'($random(seed))};
        host.xfer(1'b1, GPS_OFS_PWD_LO, 4'hF, pwd_lo, r, e);
        host.xfer(1'b1, GPS_OFS_PWD_HI, 4'hF, pwd_hi, r, e);
        for (int i = 16; i < 64; i = (i == 26) ? 63 : i + 1) begin
            host.xfer(1'b1, GPS_OFS_REPORT, 4'hF, {26'h0, i[5:0]}, r, e);
            host.xfer(1'b0, GPS_OFS_REPORT, 4'hF, 32'h0, r, e);
            `CHK(r, {18'h0, i[5:0], rep_byte(i)}, "report byte")
        end
        $display("report test done");
        host.xfer(1'b0, 8'h20, 4'hF, 32'h0, r, e);
        `CHK(e, 1'b1, "unmapped address accepted")
        cmd_test({GPS_SIG_0, GPS_SIG_1, 8'hEE}, 8'h00, 0);
        cmd_test({GPS_SIG_0, GPS_SIG_1, GPS_SIG_2}, 8'h01, 0);
        cmd_test({GPS_SIG_0, GPS_SIG_1, GPS_SIG_2}, 8'h00, GPS_RESET_PULSE_CYC);
        host.xfer(1'b0, GPS_OFS_CMD_STATUS, 4'hF, 32'h0, r, e);
        `CHK(r, 32'h0000_0102, "command counts")
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
